// File: logic/dcif_frontend.sv
// Command-input front end of a servo drive: network objects and command paths
`timescale 1ns/1ps
module dcif_frontend #(
	parameter int SEG_W = 64,
	parameter int SEG_DEPTH = 16,
	parameter bit DUAL_AXIS = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire dcif_pkg::dcif_req_t obj_req,
	output dcif_pkg::dcif_rsp_t obj_rsp,
	input wire logic [7:0] op_state,
	input wire logic profile_pos_mode,
	input wire logic seg_valid,
	input wire logic [SEG_W-1:0] seg_data,
	output logic seg_ready,
	output logic traj_seg_valid,
	output logic [SEG_W-1:0] traj_seg_data,
	input wire logic traj_seg_take,
	input wire logic step_pulse,
	input wire logic step_dir,
	output logic [31:0] master_pos,
	input wire logic [15:0] pwm_duty_first,
	input wire logic [15:0] pwm_duty_second,
	input wire logic [15:0] analog_ref_first,
	input wire logic [15:0] analog_ref_second,
	input wire logic [15:0] analog_enc_first,
	input wire logic [15:0] analog_enc_second,
	input wire logic [15:0] hall_offset,
	output logic [15:0] cmd_first,
	output logic [15:0] cmd_second,
	output logic [1:0] cmd_source,
	output logic [1:0] cmd_format,
	output logic angle_offset_en,
	output logic field_oriented_control,
	output logic two_input_active,
	input wire logic [31:0] pos_err_a,
	input wire logic [31:0] pos_err_b,
	output logic [48:0] cross_term
);

	if (SEG_DEPTH < 1 || SEG_DEPTH > 255 || SEG_W < 1) begin : g_param_check
		$error("dcif_frontend: SEG_DEPTH must be 1..255 and SEG_W at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [31:0] reg_offset;
	logic [31:0] cfg;
	logic [15:0] net_first;
	logic [15:0] net_second;
	logic [15:0] pulse_cnt;
	logic [15:0] last_cnt;
	logic [15:0] deadband;
	logic [15:0] cross_gain;
	wire [7:0] buf_used;
	wire [7:0] buf_free;

	////////////////////////////////////////////////////////////////////////////
	// Object decode

	wire [15:0] idx = obj_req.index;
	wire hit_status = idx == dcif_pkg::IDX_TRAJ_STATUS;
	wire hit_offset = idx == dcif_pkg::IDX_REG_OFFSET;
	wire hit_cfg = idx == dcif_pkg::IDX_TWO_IN_CFG;
	wire hit_first = idx == dcif_pkg::IDX_FIRST_IN;
	wire hit_second = idx == dcif_pkg::IDX_SECOND_IN;
	wire hit_cnt = idx == dcif_pkg::IDX_PULSE_CNT;
	wire hit_duty = idx == dcif_pkg::IDX_PWM_DUTY;
	wire hit_band = idx == dcif_pkg::IDX_PWM_BAND;
	wire hit_gain = idx == dcif_pkg::IDX_CROSS_GAIN;
	wire hit_ro = hit_status || hit_duty;
	wire hit_rw = hit_offset || hit_cfg || hit_first || hit_second || hit_cnt || hit_band
		|| hit_gain;
	wire wr_ok = obj_req.wr && hit_rw;
	wire req_err = (obj_req.wr && !hit_rw) || (obj_req.rd && !(hit_rw || hit_ro));
	wire req_any = obj_req.wr || obj_req.rd;

	////////////////////////////////////////////////////////////////////////////
	// Segment buffer

	wire seg_in_valid = seg_valid && profile_pos_mode;

	dcif_seg_buf #(
		.WIDTH(SEG_W),
		.DEPTH(SEG_DEPTH)
	) u_seg_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(seg_in_valid),
		.in_data(seg_data),
		.in_ready(seg_ready),
		.out_valid(traj_seg_valid),
		.out_data(traj_seg_data),
		.out_ready(traj_seg_take),
		.used(buf_used),
		.free(buf_free)
	);

	wire [31:0] status_word = {16'h0000, buf_used, buf_free};

	////////////////////////////////////////////////////////////////////////////
	// Pulse counter and master position

	wire pd_mode = op_state == dcif_pkg::STATE_PULSE_DIR;
	wire [15:0] step_delta = step_pulse ? (step_dir ? 16'h0001 : 16'hffff) : 16'h0000;
	wire [15:0] next_cnt = (wr_ok && hit_cnt) ? obj_req.wdata[15:0] : pulse_cnt + step_delta;
	wire [15:0] cnt_delta = pulse_cnt - last_cnt;
	wire [31:0] move = pd_mode ? {{16{cnt_delta[15]}}, cnt_delta} : 32'h0000_0000;
	wire [31:0] inject = pd_mode ? reg_offset : 32'h0000_0000;
	wire [31:0] next_master = master_pos + move + inject;
	wire [31:0] next_offset = (wr_ok && hit_offset) ? obj_req.wdata
		: (pd_mode ? 32'h0000_0000 : reg_offset);

	////////////////////////////////////////////////////////////////////////////
	// Two-input command path

	function automatic logic [15:0] apply_band(input logic [15:0] x, input logic [15:0] band);
		logic [16:0] mag;
		mag = x[15] ? (17'h00000 - {x[15], x}) : {1'b0, x};
		return (mag < {1'b0, band}) ? 16'h0000 : x;
	endfunction

	wire [1:0] src = cfg[dcif_pkg::CFG_SRC_LSB +: 2];
	wire [1:0] fmt = cfg[dcif_pkg::CFG_FMT_LSB +: 2];
	wire two_in_mode = op_state == dcif_pkg::STATE_TWO_INPUT;
	wire [15:0] pwm_first_db = apply_band(pwm_duty_first, deadband);
	wire [15:0] pwm_second_db = apply_band(pwm_duty_second, deadband);
	wire [15:0] raw_first = (src == dcif_pkg::SRC_PWM) ? pwm_first_db
		: (src == dcif_pkg::SRC_ANALOG_REF) ? analog_ref_first
		: (src == dcif_pkg::SRC_ANALOG_ENC) ? analog_enc_first : net_first;
	wire [15:0] raw_second = (src == dcif_pkg::SRC_PWM) ? pwm_second_db
		: (src == dcif_pkg::SRC_ANALOG_REF) ? analog_ref_second
		: (src == dcif_pkg::SRC_ANALOG_ENC) ? analog_enc_second : net_second;
	wire add_angle = cfg[dcif_pkg::CFG_ANGLE_ADD_BIT] && fmt == dcif_pkg::FMT_ANGLE_MAG;
	wire [15:0] next_second = add_angle ? raw_second + hall_offset : raw_second;
	wire net_src = src == dcif_pkg::SRC_NETWORK;
	wire [15:0] next_net_first = (wr_ok && hit_first && net_src) ? obj_req.wdata[15:0]
		: net_first;
	wire [15:0] next_net_second = (wr_ok && hit_second && net_src) ? obj_req.wdata[15:0]
		: net_second;

	////////////////////////////////////////////////////////////////////////////
	// Cross coupling

	wire signed [32:0] err_diff = $signed({pos_err_a[31], pos_err_a})
		- $signed({pos_err_b[31], pos_err_b});
	wire signed [48:0] cross_prod = err_diff * $signed(cross_gain);
	wire [48:0] next_cross = DUAL_AXIS ? cross_prod : 49'h0;

	////////////////////////////////////////////////////////////////////////////
	// Read data

	wire [31:0] rd_word = hit_status ? status_word
		: hit_offset ? reg_offset
		: hit_cfg ? cfg
		: hit_first ? {{16{cmd_first[15]}}, cmd_first}
		: hit_second ? {{16{cmd_second[15]}}, cmd_second}
		: hit_cnt ? {{16{pulse_cnt[15]}}, pulse_cnt}
		: hit_duty ? {{16{pwm_duty_first[15]}}, pwm_duty_first}
		: hit_band ? {16'h0000, deadband}
		: hit_gain ? {{16{cross_gain[15]}}, cross_gain} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_offset <= dcif_pkg::WORD32_RESET;
			master_pos <= dcif_pkg::WORD32_RESET;
			pulse_cnt <= dcif_pkg::WORD16_RESET;
			last_cnt <= dcif_pkg::WORD16_RESET;
		end else begin
			reg_offset <= next_offset;
			master_pos <= next_master;
			pulse_cnt <= next_cnt;
			last_cnt <= pulse_cnt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= dcif_pkg::CFG_RESET;
			deadband <= dcif_pkg::WORD16_RESET;
			cross_gain <= dcif_pkg::WORD16_RESET;
		end else begin
			if (wr_ok && hit_cfg) begin
				cfg <= obj_req.wdata & dcif_pkg::CFG_MASK;
			end
			if (wr_ok && hit_band) begin
				deadband <= {1'b0, obj_req.wdata[14:0]};
			end
			if (wr_ok && hit_gain) begin
				cross_gain <= obj_req.wdata[15:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			net_first <= dcif_pkg::WORD16_RESET;
			net_second <= dcif_pkg::WORD16_RESET;
			cmd_first <= dcif_pkg::WORD16_RESET;
			cmd_second <= dcif_pkg::WORD16_RESET;
			cross_term <= 49'h0;
		end else begin
			net_first <= next_net_first;
			net_second <= next_net_second;
			cmd_first <= raw_first;
			cmd_second <= next_second;
			cross_term <= next_cross;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_source <= dcif_pkg::SRC_PWM;
			cmd_format <= dcif_pkg::FMT_120_DEG;
			angle_offset_en <= 1'b0;
			field_oriented_control <= 1'b0;
			two_input_active <= 1'b0;
		end else begin
			cmd_source <= src;
			cmd_format <= fmt;
			angle_offset_en <= two_in_mode && add_angle;
			field_oriented_control <= two_in_mode && cfg[dcif_pkg::CFG_FIELD_CTL_BIT];
			two_input_active <= two_in_mode;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			obj_rsp <= '0;
		end else begin
			obj_rsp.ack <= req_any;
			obj_rsp.err <= req_any && req_err;
			obj_rsp.rdata <= (obj_req.rd && !req_err) ? rd_word : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_status_read;
		@(posedge clk) disable iff (rst)
		(obj_req.rd && hit_status) |=> obj_rsp.rdata == {16'h0000, $past(buf_used), $past(buf_free)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status word wrong");

	property p_offset_once;
		@(posedge clk) disable iff (rst)
		(pd_mode && cnt_delta == 16'h0000 && !(wr_ok && hit_offset))
		|=> master_pos == $past(master_pos) + $past(reg_offset) && reg_offset == 32'h0;
	endproperty
	a_offset_once: assert property (p_offset_once) else $error("offset not applied once");

	property p_offset_kept;
		@(posedge clk) disable iff (rst)
		(!pd_mode && !(wr_ok && hit_offset)) |=> $stable(reg_offset);
	endproperty
	a_offset_kept: assert property (p_offset_kept) else $error("offset lost outside mode");

	property p_mode_flag;
		@(posedge clk) disable iff (rst)
		1'b1 |=> two_input_active == ($past(op_state) == dcif_pkg::STATE_TWO_INPUT);
	endproperty
	a_mode_flag: assert property (p_mode_flag) else $error("two-input flag wrong");

	property p_field_ctl;
		@(posedge clk) disable iff (rst)
		field_oriented_control |-> two_input_active && $past(cfg[dcif_pkg::CFG_FIELD_CTL_BIT]);
	endproperty
	a_field_ctl: assert property (p_field_ctl) else $error("field control without mode or bit");

	property p_reserved;
		@(posedge clk) disable iff (rst)
		(cfg & ~dcif_pkg::CFG_MASK) == 32'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved config bit held");

	property p_net_first;
		@(posedge clk) disable iff (rst)
		(wr_ok && hit_first && net_src && !(wr_ok && hit_cfg)) ##1 (net_src && !obj_req.wr)
		|=> cmd_first == $past(obj_req.wdata[15:0], 2);
	endproperty
	a_net_first: assert property (p_net_first) else $error("network first input lost");

	property p_step;
		@(posedge clk) disable iff (rst)
		(step_pulse && !(wr_ok && hit_cnt))
		|=> pulse_cnt == $past(pulse_cnt) + ($past(step_dir) ? 16'h0001 : 16'hffff);
	endproperty
	a_step: assert property (p_step) else $error("pulse count wrong");

	property p_write_moves;
		@(posedge clk) disable iff (rst)
		(wr_ok && hit_cnt && !step_pulse) ##1 (pd_mode && reg_offset == 32'h0) [*2]
		|-> master_pos == $past(master_pos) + {{16{$past(cnt_delta[15])}}, $past(cnt_delta)};
	endproperty
	a_write_moves: assert property (p_write_moves) else $error("counter write not moved");

	property p_cross;
		@(posedge clk) disable iff (rst)
		1'b1 |=> cross_term == (DUAL_AXIS ? $past(cross_prod) : 49'h0);
	endproperty
	a_cross: assert property (p_cross) else $error("cross term wrong");

endmodule

// File: logic/dcif_pkg.sv
// Object indices, field layouts, mode values and carrier types of the command front end
package dcif_pkg;

	// Object indices
	localparam logic [15:0] IDX_TRAJ_STATUS = 16'h2256;
	localparam logic [15:0] IDX_REG_OFFSET = 16'h2325;
	localparam logic [15:0] IDX_TWO_IN_CFG = 16'h2326;
	localparam logic [15:0] IDX_FIRST_IN = 16'h2327;
	localparam logic [15:0] IDX_SECOND_IN = 16'h2328;
	localparam logic [15:0] IDX_PULSE_CNT = 16'h2329;
	localparam logic [15:0] IDX_PWM_DUTY = 16'h232a;
	localparam logic [15:0] IDX_PWM_BAND = 16'h232b;
	localparam logic [15:0] IDX_CROSS_GAIN = 16'h2378;

	// Operating state select values
	localparam logic [7:0] STATE_PULSE_DIR = 8'h17;
	localparam logic [7:0] STATE_TWO_INPUT = 8'h05;

	// Buffer status field positions
	localparam int STAT_FREE_LSB = 0;
	localparam int STAT_FULL_LSB = 8;
	localparam int STAT_CNT_W = 8;

	// Two-input configuration fields
	localparam int CFG_SRC_LSB = 0;
	localparam int CFG_FMT_LSB = 8;
	localparam int CFG_ANGLE_ADD_BIT = 16;
	localparam int CFG_FIELD_CTL_BIT = 17;
	localparam logic [31:0] CFG_MASK = 32'h0003_0303;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// Command sources and formats
	localparam logic [1:0] SRC_PWM = 2'h0;
	localparam logic [1:0] SRC_ANALOG_REF = 2'h1;
	localparam logic [1:0] SRC_ANALOG_ENC = 2'h2;
	localparam logic [1:0] SRC_NETWORK = 2'h3;
	localparam logic [1:0] FMT_120_DEG = 2'h0;
	localparam logic [1:0] FMT_90_DEG = 2'h1;
	localparam logic [1:0] FMT_ANGLE_MAG = 2'h2;

	// Reset values
	localparam logic [15:0] WORD16_RESET = 16'h0000;
	localparam logic [31:0] WORD32_RESET = 32'h0000_0000;

	// Object access request and answer
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] index;
		logic [31:0] wdata;
	} dcif_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} dcif_rsp_t;

endpackage

// File: logic/dcif_seg_buf.sv
// Trajectory segment buffer: shift-register queue with occupancy counts
`timescale 1ns/1ps
module dcif_seg_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [7:0] used,
	output logic [7:0] free
);

	if (DEPTH < 1 || DEPTH > 255 || WIDTH < 1) begin : g_param_check
		$error("dcif_seg_buf: DEPTH must be 1..255 and WIDTH at least 1");
	end

	localparam logic [7:0] DEPTH_W = 8'(DEPTH);

	logic [WIDTH-1:0] entry [DEPTH];
	logic [7:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [7:0] next_count = count + {7'h0, push} - {7'h0, pop};

	// Head at entry 0; a pop shifts all entries down
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			wire [WIDTH-1:0] upper = (i < DEPTH - 1) ? entry[(i < DEPTH - 1) ? i + 1 : i] : entry[i];
			wire load_pop = pop && push && (8'(i) == count - 8'h01);
			wire load_idle = !pop && push && (8'(i) == count);
			wire [WIDTH-1:0] next_entry = (load_pop || load_idle) ? in_data : (pop ? upper : entry[i]);
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					entry[i] <= '0;
				end else begin
					entry[i] <= next_entry;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 8'h00;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			used <= 8'h00;
			free <= DEPTH_W;
		end else begin
			count <= next_count;
			in_ready <= next_count != DEPTH_W;
			out_valid <= next_count != 8'h00;
			used <= next_count;
			free <= DEPTH_W - next_count;
		end
	end

	assign out_data = entry[0];

endmodule

// File: testbench/dcif_master.sv
// Network master model issuing object reads and writes
`timescale 1ns/1ps
module dcif_master (
	input wire logic clk,
	output dcif_pkg::dcif_req_t obj_req,
	input wire dcif_pkg::dcif_rsp_t obj_rsp
);
	initial begin
		obj_req = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One request pulse, then a bounded wait for the answer
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic er, output logic ok);
		ok = 1'b0;
		rd = 32'h0;
		er = 1'b0;
		@(posedge clk);
		obj_req <= '{rd: ~wr, wr: wr, index: idx, wdata: wd};
		@(posedge clk);
		obj_req <= '0;
		for (int i = 0; i < 3 && !ok; i++) begin
			#1;
			if (obj_rsp.ack === 1'b1) begin
				ok = 1'b1;
				rd = obj_rsp.rdata;
				er = obj_rsp.err;
			end else begin
				@(posedge clk);
			end
		end
	endtask
endmodule

// File: testbench/tb_drive_command_input_frontend.sv
// Self-checking bench of the command-input front end
`timescale 1ns/1ps
module tb_drive_command_input_frontend;
	localparam int DEPTH = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dcif_pkg::dcif_req_t obj_req;
	dcif_pkg::dcif_rsp_t obj_rsp;
	logic [7:0] op_state = 8'h00;
	logic profile_pos_mode = 1'b0;
	logic seg_valid = 1'b0;
	logic [63:0] seg_data = 64'h0;
	logic traj_seg_take = 1'b0;
	logic step_pulse = 1'b0;
	logic step_dir = 1'b0;
	logic [15:0] pwm1 = 16'hffce;
	logic [15:0] pwm2 = 16'h0064;
	logic [15:0] ref1 = 16'h0;
	logic [15:0] ref2 = 16'h0;
	logic [15:0] enc1 = 16'h0;
	logic [15:0] enc2 = 16'h0;
	logic [15:0] hall = 16'h0;
	logic [31:0] err_a = 32'h0;
	logic [31:0] err_b = 32'h0;
	logic seg_ready;
	logic traj_seg_valid;
	logic [63:0] traj_seg_data;
	logic [31:0] master_pos;
	logic [15:0] cmd_first;
	logic [15:0] cmd_second;
	logic [1:0] cmd_source;
	logic [1:0] cmd_format;
	logic angle_en;
	logic field_ctl;
	logic two_act;
	logic [48:0] cross_term;
	int errors = 0;
	int checks = 0;

	always #20 clk = ~clk;

	dcif_frontend #(.SEG_W(64), .SEG_DEPTH(DEPTH), .DUAL_AXIS(1'b1)) dut_u (
		.clk(clk), .rst(rst), .obj_req(obj_req), .obj_rsp(obj_rsp), .op_state(op_state),
		.profile_pos_mode(profile_pos_mode), .seg_valid(seg_valid), .seg_data(seg_data),
		.seg_ready(seg_ready), .traj_seg_valid(traj_seg_valid), .traj_seg_data(traj_seg_data),
		.traj_seg_take(traj_seg_take), .step_pulse(step_pulse), .step_dir(step_dir),
		.master_pos(master_pos), .pwm_duty_first(pwm1), .pwm_duty_second(pwm2),
		.analog_ref_first(ref1), .analog_ref_second(ref2), .analog_enc_first(enc1),
		.analog_enc_second(enc2), .hall_offset(hall), .cmd_first(cmd_first),
		.cmd_second(cmd_second), .cmd_source(cmd_source), .cmd_format(cmd_format),
		.angle_offset_en(angle_en), .field_oriented_control(field_ctl), .two_input_active(two_act),
		.pos_err_a(err_a), .pos_err_b(err_b), .cross_term(cross_term)
	);

	dcif_master master_u (.clk(clk), .obj_req(obj_req), .obj_rsp(obj_rsp));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		logic ok;
		master_u.xfer(wr, idx, wd, rd, er, ok);
		if (!ok) begin
			errors++;
			$display("ERROR %0t no answer", $time);
			report_and_stop();
		end
	endtask

	task automatic wr_obj(input logic [15:0] idx, input logic [31:0] wd, input logic exp_er);
		logic [31:0] rd;
		logic er;
		acc(1'b1, idx, wd, rd, er);
		check(64'(er), 64'(exp_er));
	endtask

	task automatic rd_obj(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic er;
		acc(1'b0, idx, 32'h0, rd, er);
		check(64'(er), 64'h0);
		check(64'(rd), 64'(exp));
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic push(input int n, input logic [63:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			seg_valid <= 1'b1;
			seg_data <= base + 64'(i);
		end
		@(posedge clk);
		seg_valid <= 1'b0;
	endtask

	task automatic steps(input int n, input logic dir);
		@(posedge clk);
		step_pulse <= 1'b1;
		step_dir <= dir;
		repeat (n) @(posedge clk);
		step_pulse <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [15:0] e1 [3];
		logic [15:0] e2 [3];
		e1 = '{16'h0000, 16'h1234, 16'hedcb};
		e2 = '{16'h0064, 16'h0f00, 16'h0133};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wait_cyc(1);
		check(64'(seg_ready), 64'h1);
		rd_obj(dcif_pkg::IDX_TRAJ_STATUS, 32'(DEPTH));
		push(1, 64'h0);
		wait_cyc(2);
		rd_obj(dcif_pkg::IDX_TRAJ_STATUS, 32'(DEPTH));
		@(posedge clk);
		profile_pos_mode <= 1'b1;
		push(DEPTH + 1, 64'ha0);
		wait_cyc(2);
		check(64'(seg_ready), 64'h0);
		check(64'(traj_seg_valid), 64'h1);
		rd_obj(dcif_pkg::IDX_TRAJ_STATUS, 32'(DEPTH << 8));
		check(traj_seg_data, 64'ha0);
		@(posedge clk);
		traj_seg_take <= 1'b1;
		@(posedge clk);
		traj_seg_take <= 1'b0;
		wait_cyc(2);
		check(traj_seg_data, 64'ha1);
		rd_obj(dcif_pkg::IDX_TRAJ_STATUS, 32'(((DEPTH - 1) << 8) + 1));
		wr_obj(dcif_pkg::IDX_TRAJ_STATUS, 32'h1, 1'b1);
		wr_obj(dcif_pkg::IDX_PWM_DUTY, 32'h1, 1'b1);
		wr_obj(16'h1234, 32'h1, 1'b1);
		// Pulse counter outside pulse mode
		wr_obj(dcif_pkg::IDX_PULSE_CNT, 32'h0000_fffe, 1'b0);
		rd_obj(dcif_pkg::IDX_PULSE_CNT, 32'hffff_fffe);
		steps(7, 1'b1);
		wait_cyc(2);
		rd_obj(dcif_pkg::IDX_PULSE_CNT, 32'h5);
		// Registration offset
		wr_obj(dcif_pkg::IDX_REG_OFFSET, 32'd100, 1'b0);
		rd_obj(dcif_pkg::IDX_REG_OFFSET, 32'd100);
		check(64'(master_pos), 64'h0);
		@(posedge clk);
		op_state <= dcif_pkg::STATE_PULSE_DIR;
		wait_cyc(3);
		check(64'(master_pos), 64'd100);
		rd_obj(dcif_pkg::IDX_REG_OFFSET, 32'h0);
		steps(3, 1'b1);
		wait_cyc(3);
		check(64'(master_pos), 64'd103);
		rd_obj(dcif_pkg::IDX_PULSE_CNT, 32'd8);
		// Deliberate counter write in pulse mode, normally avoided by the master
		wr_obj(dcif_pkg::IDX_PULSE_CNT, 32'd18, 1'b0);
		wait_cyc(3);
		check(64'(master_pos), 64'd113);
		wr_obj(dcif_pkg::IDX_REG_OFFSET, 32'hffff_fff0, 1'b0);
		wait_cyc(3);
		check(64'(master_pos), 64'd97);
		wait_cyc(5);
		check(64'(master_pos), 64'd97);
		rd_obj(dcif_pkg::IDX_REG_OFFSET, 32'h0);
		// Two-input current-command mode
		@(posedge clk);
		op_state <= dcif_pkg::STATE_TWO_INPUT;
		ref1 <= 16'h1234;
		ref2 <= 16'h0f00;
		enc1 <= 16'hedcb;
		enc2 <= 16'h0123;
		hall <= 16'h0010;
		wr_obj(dcif_pkg::IDX_PWM_BAND, 32'h0000_7fff, 1'b0);
		rd_obj(dcif_pkg::IDX_PWM_BAND, 32'h0000_7fff);
		wr_obj(dcif_pkg::IDX_PWM_BAND, 32'h0000_0064, 1'b0);
		rd_obj(dcif_pkg::IDX_PWM_DUTY, 32'hffff_ffce);
		for (int s = 0; s < 3; s++) begin
			wr_obj(dcif_pkg::IDX_TWO_IN_CFG, 32'h0001_0000 | 32'(s << 8) | 32'(s), 1'b0);
			wr_obj(dcif_pkg::IDX_FIRST_IN, 32'h0000_5555, 1'b0);
			wait_cyc(3);
			check(64'(cmd_source), 64'(s));
			check(64'(cmd_format), 64'(s));
			check(64'({angle_en, field_ctl, two_act}), (s == 2) ? 64'h5 : 64'h1);
			check(64'(cmd_first), 64'(e1[s]));
			check(64'(cmd_second), 64'(e2[s]));
			rd_obj(dcif_pkg::IDX_FIRST_IN, {{16{e1[s][15]}}, e1[s]});
			rd_obj(dcif_pkg::IDX_SECOND_IN, {{16{e2[s][15]}}, e2[s]});
		end
		wr_obj(dcif_pkg::IDX_TWO_IN_CFG, 32'hffff_ffff, 1'b0);
		rd_obj(dcif_pkg::IDX_TWO_IN_CFG, 32'h0003_0303);
		wait_cyc(3);
		check(64'(cmd_first), 64'h0);
		check(64'(field_ctl), 64'h1);
		wr_obj(dcif_pkg::IDX_FIRST_IN, 32'h0000_8001, 1'b0);
		wr_obj(dcif_pkg::IDX_SECOND_IN, 32'h0000_7ffe, 1'b0);
		wait_cyc(3);
		check(64'(cmd_first), 64'h8001);
		check(64'(cmd_second), 64'h7ffe);
		rd_obj(dcif_pkg::IDX_FIRST_IN, 32'hffff_8001);
		@(posedge clk);
		op_state <= 8'h00;
		wait_cyc(3);
		check(64'({field_ctl, two_act}), 64'h0);
		// Cross-coupling gain
		@(posedge clk);
		err_a <= 32'd10;
		err_b <= 32'd3;
		wr_obj(dcif_pkg::IDX_CROSS_GAIN, 32'h0000_fffd, 1'b0);
		rd_obj(dcif_pkg::IDX_CROSS_GAIN, 32'hffff_fffd);
		wait_cyc(3);
		check(64'(cross_term), 64'h0001_ffff_ffff_ffeb);
		report_and_stop();
	end
endmodule
